// ### shared/amplg_defines.vh
// constants for the alert mask/enable and power-good upper-limit register block
// assumes a register port driven by the serial-bus front end, one access per strobe
//
// Overview of operation
// - reading mask/enable clears all read-clear flags
// - writing mask/enable changes control fields only
// - bits 14-12 pick channels for shunt sum
// - sum selection leaves channel enables untouched
// - bit 11 makes warning output latch
// - bit 10 makes critical output latch
// - bits 9-7 critical flags, assert critical output
// - read clears the three critical flags
// - bit 6 set when sum exceeds limit
// - sum flag also asserts critical output
// - read clears the sum flag
// - bits 5-3 warning flags, assert warning output
// - read clears the warning flags
// - bit 2 follows power-good, read never clears
// - bit 1 timing flag, resets high, sticky
// - bit 0 set when measurement cycle completes
// - conversion-ready clears on read or config write; config writes in power-down modes 0 and 4 leave it set
// - power-good high when all buses exceed limit
// - power-good only while bus measurement enabled
// - upper limit 8 mV steps, reset 10.000 V
// - limit sign bit 15, magnitude 14-3
`ifndef AMPLG_DEFINES_VH
`define AMPLG_DEFINES_VH

// register offsets
`define AMPLG_ADDR_MASK_ENABLE 8'h0F
`define AMPLG_ADDR_PG_UPPER 8'h10

// reset values
`define AMPLG_RST_MASK_ENABLE 16'h0002
`define AMPLG_RST_PG_UPPER 16'h2710

// mask/enable field positions
`define AMPLG_BIT_RSVD 15
`define AMPLG_SUM_SEL_HI 14
`define AMPLG_SUM_SEL_LO 12
`define AMPLG_BIT_WARN_LATCH 11
`define AMPLG_BIT_CRIT_LATCH 10
`define AMPLG_CRIT_FLAG_HI 9
`define AMPLG_CRIT_FLAG_LO 7
`define AMPLG_BIT_SUM_FLAG 6
`define AMPLG_WARN_FLAG_HI 5
`define AMPLG_WARN_FLAG_LO 3
`define AMPLG_BIT_PG_FLAG 2
`define AMPLG_BIT_TC_FLAG 1
`define AMPLG_BIT_CONV_READY 0

// upper-limit field layout: sign and magnitude, low bits reserved
`define AMPLG_LIMIT_MASK 16'hFFF8

// operating mode codes that do not clear conversion-ready
`define AMPLG_MODE_PWRDN_A 3'h0
`define AMPLG_MODE_PWRDN_B 3'h4

`define AMPLG_NUM_CH 3

`endif

// ### hdl/amplg_alert_out.v
// alert output stage: transparent or latching follower of an alert condition
// assumes cond is refreshed by the owner on each evaluation and clr is a read pulse
`timescale 1ns/1ps

module amplg_alert_out
(
   input wire sys_clk,
   input wire resetn,
   input wire clk_en,
   input wire cond,
   input wire latch_en,
   input wire clr,
   output wire alert
);

reg alert_r;
reg alert_nxt;

// latch mode holds until read; a live condition always wins over the clear
always @*
begin
   if (latch_en)
      alert_nxt = cond | (alert_r & ~clr);
   else
      alert_nxt = cond;
end

always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      alert_r <= 1'b0;
   else if (clk_en)
      alert_r <= alert_nxt;
end

assign alert = alert_r;

endmodule

// ### hdl/amplg_alert_regs.v
// mask/enable register and power-good upper-limit register with flag and alert logic
// assumes measurement results and their completion strobes come from the datapath,
// and that register strobes are single-cycle pulses from the serial-bus front end
// a flag set by the datapath wins over a read clear landing in the same cycle
`timescale 1ns/1ps
`include "amplg_defines.vh"

module amplg_alert_regs
(
   input wire sys_clk,
   input wire resetn,
   input wire clk_en,
   // register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output wire [15:0] reg_rdata,
   // per-channel results from the measurement datapath
   input wire [2:0] crit_eval,
   input wire [2:0] crit_exceed,
   input wire [2:0] warn_eval,
   input wire [2:0] warn_exceed,
   input wire sum_eval,
   input wire sum_exceed,
   input wire bus_eval,
   input wire [47:0] bus_volt,
   input wire bus_below_lower,
   input wire cycle_done,
   input wire tc_event,
   input wire sw_reset,
   // configuration register activity
   input wire cfg_write,
   input wire [2:0] operating_mode_field,
   input wire bus_meas_en,
   // outputs
   output wire [2:0] sum_channel_select,
   output wire critical_alert,
   output wire warning_alert,
   output wire power_good_output,
   output wire timing_control_output
);

////////////////////////////////////////////////////////////////////////
// decode

wire hit_mask;
wire hit_limit;
wire rd_mask;
wire wr_mask;
wire wr_limit;

// only a read of mask/enable clears flags; other reads have no side effect
assign hit_mask = (reg_addr == `AMPLG_ADDR_MASK_ENABLE);
assign hit_limit = (reg_addr == `AMPLG_ADDR_PG_UPPER);
assign rd_mask = reg_rd & hit_mask;
assign wr_mask = reg_wr & hit_mask;
assign wr_limit = reg_wr & hit_limit;

////////////////////////////////////////////////////////////////////////
// control fields of mask/enable

reg rsvd_r;
reg [2:0] sum_sel_r;
reg warn_latch_r;
reg crit_latch_r;

// reset image of the mask/enable word
localparam [15:0] MASK_RST = `AMPLG_RST_MASK_ENABLE;

// bit 15 is kept as written so a read returns what the host stored
// write touches controls only
always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
   begin
      rsvd_r <= MASK_RST[`AMPLG_BIT_RSVD];
      sum_sel_r <= MASK_RST[`AMPLG_SUM_SEL_HI:`AMPLG_SUM_SEL_LO];
      warn_latch_r <= MASK_RST[`AMPLG_BIT_WARN_LATCH];
      crit_latch_r <= MASK_RST[`AMPLG_BIT_CRIT_LATCH];
   end
   else if (clk_en && wr_mask)
   begin
      rsvd_r <= reg_wdata[`AMPLG_BIT_RSVD];
      sum_sel_r <= reg_wdata[`AMPLG_SUM_SEL_HI:`AMPLG_SUM_SEL_LO];
      warn_latch_r <= reg_wdata[`AMPLG_BIT_WARN_LATCH];
      crit_latch_r <= reg_wdata[`AMPLG_BIT_CRIT_LATCH];
   end
end

// selection drives only the sum path
assign sum_channel_select = sum_sel_r;

////////////////////////////////////////////////////////////////////////
// power-good upper limit

reg [15:0] pg_limit_r;

// reserved low bits are kept as written; the compare ignores them
// reset to the 10 V code
always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      pg_limit_r <= `AMPLG_RST_PG_UPPER;
   else if (clk_en && wr_limit)
      pg_limit_r <= reg_wdata;
end

////////////////////////////////////////////////////////////////////////
// per-channel flags and conditions

reg [2:0] crit_flag_r;
reg [2:0] warn_flag_r;
reg [2:0] crit_cond_r;
reg [2:0] warn_cond_r;
wire [2:0] bus_above;
wire [2:0] crit_cond_nxt;
wire [2:0] warn_cond_nxt;

// one slice per channel: flags, held conditions and the power-good compare
genvar ch;
generate
   for (ch = 0; ch < `AMPLG_NUM_CH; ch = ch + 1)
   begin : g_ch
      wire crit_set;
      wire warn_set;
      wire [15:0] volt;

      assign crit_set = crit_eval[ch] & crit_exceed[ch];
      assign warn_set = warn_eval[ch] & warn_exceed[ch];
      assign volt = bus_volt[ch*16 +: 16];
      assign bus_above[ch] = $signed(volt & `AMPLG_LIMIT_MASK) > $signed(pg_limit_r & `AMPLG_LIMIT_MASK);

      // next held condition: a fresh result replaces the old one
      assign crit_cond_nxt[ch] = crit_eval[ch] ? crit_exceed[ch] : crit_cond_r[ch];
      assign warn_cond_nxt[ch] = warn_eval[ch] ? warn_exceed[ch] : warn_cond_r[ch];

      // flags are sticky until the host reads mask/enable

      always @(posedge sys_clk or negedge resetn)
      begin
         if (!resetn)
            crit_flag_r[ch] <= 1'b0;
         else if (clk_en)
            crit_flag_r[ch] <= crit_set | (crit_flag_r[ch] & ~rd_mask);
      end

      always @(posedge sys_clk or negedge resetn)
      begin
         if (!resetn)
            warn_flag_r[ch] <= 1'b0;
         else if (clk_en)
            warn_flag_r[ch] <= warn_set | (warn_flag_r[ch] & ~rd_mask);
      end

      always @(posedge sys_clk or negedge resetn)
      begin
         if (!resetn)
         begin
            crit_cond_r[ch] <= 1'b0;
            warn_cond_r[ch] <= 1'b0;
         end
         else if (clk_en)
         begin
            crit_cond_r[ch] <= crit_cond_nxt[ch];
            warn_cond_r[ch] <= warn_cond_nxt[ch];
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// summation flag

reg sum_flag_r;
reg sum_cond_r;
wire sum_cond_nxt;

// held sum condition, replaced by each fresh sum result
assign sum_cond_nxt = sum_eval ? sum_exceed : sum_cond_r;

always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
   begin
      sum_flag_r <= 1'b0;
      sum_cond_r <= 1'b0;
   end
   else if (clk_en)
   begin
      sum_flag_r <= (sum_eval & sum_exceed) | (sum_flag_r & ~rd_mask);
      sum_cond_r <= sum_cond_nxt;
   end
end

////////////////////////////////////////////////////////////////////////
// alert outputs

wire crit_any;
wire warn_any;

// the alert stages see each condition as it stands after this edge,
// so an alert moves in the same cycle as its flag, not one later
// sum condition feeds critical too
assign crit_any = (|crit_cond_nxt) | sum_cond_nxt;
assign warn_any = |warn_cond_nxt;

// latched stages clear on a mask/enable read once their condition is gone; transparent ones drop with the condition
// critical transparent or latched
amplg_alert_out u_crit
(
   .sys_clk(sys_clk),
   .resetn(resetn),
   .clk_en(clk_en),
   .cond(crit_any),
   .latch_en(crit_latch_r),
   .clr(rd_mask),
   .alert(critical_alert)
);

amplg_alert_out u_warn
(
   .sys_clk(sys_clk),
   .resetn(resetn),
   .clk_en(clk_en),
   .cond(warn_any),
   .latch_en(warn_latch_r),
   .clr(rd_mask),
   .alert(warning_alert)
);

////////////////////////////////////////////////////////////////////////
// power-good output and flag

reg pg_r;
reg pg_nxt;

// a reading below the lower limit or a mode without bus conversions
// drops power-good at once; raising it needs a fresh set of readings
// all channels above limit raise it
always @*
begin
   pg_nxt = pg_r;
   if (!bus_meas_en || bus_below_lower)
      pg_nxt = 1'b0;
   else if (bus_eval && (&bus_above))
      pg_nxt = 1'b1;
end

always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      pg_r <= 1'b0;
   else if (clk_en)
      pg_r <= pg_nxt;
end

assign power_good_output = pg_r;

////////////////////////////////////////////////////////////////////////
// timing-control output and flag

reg tc_r;

// an event and a software reset in one cycle leave the output high
// comes up high, cleared only by software reset
always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      tc_r <= MASK_RST[`AMPLG_BIT_TC_FLAG];
   else if (clk_en)
   begin
      if (tc_event)
         tc_r <= 1'b1;
      else if (sw_reset)
         tc_r <= 1'b0;
   end
end

assign timing_control_output = tc_r;

////////////////////////////////////////////////////////////////////////
// conversion-ready flag

reg conv_ready_r;
wire cfg_clear;

// power-down and disabled modes keep the flag, so parking the converter
// does not lose a finished single-shot result
assign cfg_clear = cfg_write & (operating_mode_field != `AMPLG_MODE_PWRDN_A) &
                   (operating_mode_field != `AMPLG_MODE_PWRDN_B);

// read or config write clears, set wins
always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      conv_ready_r <= 1'b0;
   else if (clk_en)
      conv_ready_r <= cycle_done | (conv_ready_r & ~(rd_mask | cfg_clear));
end

////////////////////////////////////////////////////////////////////////
// read data

reg [15:0] rdata_r;
reg [15:0] rdata_nxt;
wire [15:0] mask_view;

// mask/enable word as the host sees it, msb first
assign mask_view = {rsvd_r, sum_sel_r, warn_latch_r, crit_latch_r, crit_flag_r, sum_flag_r,
                    warn_flag_r, pg_r, tc_r, conv_ready_r};

// read data are taken in the strobe cycle, so a clear-on-read
// never shows in the word the host is fetching
// read returns flags before clearing
always @*
begin
   if (hit_mask)
      rdata_nxt = mask_view;
   else if (hit_limit)
      rdata_nxt = pg_limit_r;
   else
      rdata_nxt = 16'h0000;
end

// capture on any read strobe; unmapped addresses read as zero
always @(posedge sys_clk or negedge resetn)
begin
   if (!resetn)
      rdata_r <= 16'h0000;
   else if (clk_en && reg_rd)
      rdata_r <= rdata_nxt;
end

assign reg_rdata = rdata_r;

endmodule

// ### tb/amplg_monitor.sv
// port checker for the alert register block
// assumes it is bound onto every amplg_alert_regs
`timescale 1ns/1ps
module amplg_monitor
(
   input wire sys_clk,
   input wire resetn,
   input wire clk_en,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata,
   input wire [2:0] crit_eval,
   input wire [2:0] crit_exceed,
   input wire sum_eval,
   input wire sum_exceed,
   input wire bus_below_lower,
   input wire tc_event,
   input wire sw_reset,
   input wire bus_meas_en,
   input wire [2:0] sum_channel_select,
   input wire critical_alert,
   input wire power_good_output,
   input wire timing_control_output
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   // register port and alert relations
   property p_sel; clk_en && reg_wr && reg_addr == 8'h0F |=> sum_channel_select == $past(reg_wdata[14:12]); endproperty
   a_sel: assert property (p_sel) else $error("sum select not taken");
   property p_crit; clk_en && |(crit_eval & crit_exceed) |=> critical_alert; endproperty
   a_crit: assert property (p_crit) else $error("critical alert missing");
   property p_sum; clk_en && sum_eval && sum_exceed |=> critical_alert; endproperty
   a_sum: assert property (p_sum) else $error("sum alert missing");
   property p_pgoff; clk_en && !bus_meas_en |=> !power_good_output; endproperty
   a_pgoff: assert property (p_pgoff) else $error("power good without bus");
   property p_pglow; clk_en && bus_below_lower |=> !power_good_output; endproperty
   a_pglow: assert property (p_pglow) else $error("power good kept");
   property p_tc; clk_en && tc_event |=> timing_control_output; endproperty
   a_tc: assert property (p_tc) else $error("timing output missing");
   property p_tcst; timing_control_output && !(clk_en && sw_reset) |=> timing_control_output; endproperty
   a_tcst: assert property (p_tcst) else $error("timing output dropped");
   property p_rdpg; clk_en && reg_rd && reg_addr == 8'h0F |=> reg_rdata[2:1] == $past({power_good_output,
      timing_control_output}); endproperty
   a_rdpg: assert property (p_rdpg) else $error("flag mirror wrong");
endmodule
bind amplg_alert_regs amplg_monitor amplg_monitor_i (.sys_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .crit_eval, .crit_exceed, .sum_eval, .sum_exceed, .bus_below_lower, .tc_event,
   .sw_reset, .bus_meas_en, .sum_channel_select, .critical_alert, .power_good_output, .timing_control_output);

// ### tb/amplg_host.sv
// host model driving the register port
// assumes tb_top calls its tasks and drains exp_q
`timescale 1ns/1ps
module amplg_host
(
   input wire sys_clk,
   output reg [7:0] reg_addr = 8'h00,
   output reg reg_wr = 1'b0,
   output reg reg_rd = 1'b0,
   output reg [15:0] reg_wdata = 16'h0000
);
   // expected read data, oldest first
   logic [15:0] exp_q[$];
   // one write strobe, data scrambled afterwards
   task wr(input [7:0] a, input [15:0] d);
   begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   end
   endtask
   // one read strobe, expected data noted first
   task rd(input [7:0] a, input [15:0] e);
   begin
      @(posedge sys_clk);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   end
   endtask
   task setup(input [15:0] d, input [15:0] e);
   begin
      rd(8'h0F, e);
      wr(8'h0F, d);
   end
   endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the alert register block
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_top;
   reg sys_clk = 1'b0;
   reg resetn = 1'b0;
   reg [11:0] stb = 12'h000;
   reg [8:0] lv = 9'h000;
   reg [47:0] bus_volt = 48'h0;
   reg [2:0] mode = 3'h0;
   reg rd_seen = 1'b0;
   reg ce = 1'b1;
   reg [15:0] e;
   reg [15:0] r = 16'h0020;
   integer i;
   integer num_errors = 0;
   integer cmp_count = 0;
   wire [7:0] reg_addr;
   wire reg_wr;
   wire reg_rd;
   wire [15:0] reg_wdata;
   wire [15:0] reg_rdata;
   wire [6:0] outs;
   always #10 sys_clk = ~sys_clk;
   amplg_host amplg_host_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   amplg_alert_regs amplg_alert_regs_i (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .crit_eval(stb[11:9]), .crit_exceed(lv[8:6]), .warn_eval(stb[8:6]), .warn_exceed(lv[5:3]),
      .sum_eval(stb[5]), .sum_exceed(lv[2]), .bus_eval(stb[4]), .bus_volt(bus_volt),
      .bus_below_lower(lv[1]), .cycle_done(stb[3]), .tc_event(stb[2]), .sw_reset(stb[1]),
      .cfg_write(stb[0]), .operating_mode_field(mode), .bus_meas_en(lv[0]),
      .sum_channel_select(outs[6:4]), .critical_alert(outs[3]), .warning_alert(outs[2]),
      .power_good_output(outs[1]), .timing_control_output(outs[0]));
   function [15:0] lfsr(input [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // strobes for one cycle, levels held
   task pl(input [11:0] s, input [8:0] l);
   begin
      @(posedge sys_clk);
      stb <= s;
      lv <= l;
      @(posedge sys_clk);
      stb <= 12'h000;
   end
   endtask
   // output levels compare
   task ol(input [6:0] x);
   begin
      @(negedge sys_clk);
      cmp_count++;
      if (outs !== x)
      begin
         $display("BAD outs exp %h got %h", x, outs);
         num_errors++;
      end
   end
   endtask
   task end_sim;
   begin
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   // read data against the oldest note
   always @(posedge sys_clk) rd_seen <= reg_rd;
   always @(negedge sys_clk)
   begin
      if (rd_seen)
      begin
         e = amplg_host_i.exp_q.pop_front();
         cmp_count++;
         if (reg_rdata !== e)
         begin
            $display("BAD reg_rdata exp %h got %h", e, reg_rdata);
            num_errors++;
         end
      end
   end
   // watchdog
   initial
   begin
      #100000;
      num_errors++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      ol(7'h01);
      amplg_host_i.rd(8'h0F, 16'h0002);
      amplg_host_i.rd(8'h10, 16'h2710);
      amplg_host_i.rd(8'h33, 16'h0000);
      amplg_host_i.wr(8'h0F, 16'hFFFF);
      ol(7'h71);
      amplg_host_i.setup(16'h0000, 16'hFC02);
      for (i = 0; i < 4; i++)
      begin
         r = lfsr(r);
         amplg_host_i.wr(8'h10, r);
         amplg_host_i.rd(8'h10, r);
      end
      amplg_host_i.wr(8'h10, 16'h2710);
      $display("test registers done");
      for (i = 0; i < 3; i++)
      begin
         pl({3'd1 << i, 3'd1 << i, 6'h00}, {3'd1 << i, 3'd1 << i, 3'h0});
         ol(7'h0D);
         amplg_host_i.rd(8'h0F, 16'h0002 | (16'h0088 << i));
         pl(12'hFC0, 9'h000);
         ol(7'h01);
      end
      amplg_host_i.rd(8'h0F, 16'h0002);
      pl(12'h020, 9'h004);
      ol(7'h09);
      amplg_host_i.rd(8'h0F, 16'h0042);
      pl(12'h020, 9'h000);
      $display("test flags done");
      amplg_host_i.wr(8'h0F, 16'h0C00);
      pl(12'h240, 9'h048);
      pl(12'hFC0, 9'h000);
      ol(7'h0D);
      amplg_host_i.rd(8'h0F, 16'h0C8A);
      ol(7'h01);
      amplg_host_i.wr(8'h0F, 16'h0000);
      $display("test latch done");
      bus_volt <= {16'h2718, 16'h2717, 16'h2718};
      pl(12'h010, 9'h001);
      ol(7'h01);
      bus_volt <= {16'h2718, 16'h2718, 16'h2718};
      pl(12'h010, 9'h001);
      ol(7'h03);
      amplg_host_i.rd(8'h0F, 16'h0006);
      amplg_host_i.rd(8'h0F, 16'h0006);
      pl(12'h000, 9'h000);
      ol(7'h01);
      pl(12'h010, 9'h001);
      pl(12'h000, 9'h003);
      ol(7'h01);
      $display("test power good done");
      pl(12'h002, 9'h000);
      ol(7'h00);
      amplg_host_i.rd(8'h0F, 16'h0000);
      pl(12'h006, 9'h000);
      ol(7'h01);
      ce <= 1'b0;
      pl(12'h002, 9'h000);
      ol(7'h01);
      ce <= 1'b1;
      pl(12'h008, 9'h000);
      pl(12'h001, 9'h000);
      mode <= 3'h4;
      pl(12'h001, 9'h000);
      amplg_host_i.rd(8'h0F, 16'h0003);
      mode <= 3'h1;
      pl(12'h008, 9'h000);
      pl(12'h001, 9'h000);
      amplg_host_i.rd(8'h0F, 16'h0002);
      ol(7'h01);
      $display("test timing and ready done");
      @(posedge sys_clk);
      end_sim;
   end
endmodule
